/* File: hdl/ldi_top.sv */
// Lead-detect configuration and interrupt-enable register bank
`timescale 1ns/1ps
`include "ldi_regs.svh"
module ldi_top #(
  parameter int unsigned QUAL_CYCLES = `LDI_QUAL_CYCLES,
  parameter logic [7:0]  CHIP_ID     = `LDI_CHIPID_VAL
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire ldi_pkg::ldi_req_type reg_req,
  output logic [7:0]                reg_rdata,
  output logic                      reg_rvalid,
  input  wire ldi_pkg::ldi_mode_type mode,
  input  wire logic [3:0]           window_cmp,
  input  wire logic [7:0]           status0_in,
  input  wire logic [3:0]           status1_hi_in,
  output logic                      irq,
  output logic                      current_source_enable,
  output logic [6:0]                current_na,
  output logic [9:0]                window_mv,
  output logic [7:0]                bias_megohm,
  output logic                      pos_bias_connect,
  output logic                      neg_bias_connect,
  output logic                      leadoff_detect_active,
  output logic                      leadon_detect_active,
  output logic [3:0]                input_off_flags
);
  import ldi_pkg::*;

  ldi_cfg_type cfg;
  ldi_cfg_type next_cfg;
  logic [7:0]  en0;
  logic [7:0]  next_en0;
  logic [7:0]  en1;
  logic [7:0]  next_en1;
  logic [7:0]  next_rdata;
  logic        next_rvalid;
  logic [7:0]  st0;
  logic [7:0]  st1;
  logic        loff_live;
  logic        chan_on;
  logic        next_irq;
  logic        next_cur_en;
  logic [6:0]  next_na;
  logic [9:0]  next_win;
  logic [7:0]  next_mohm;
  logic        next_lon_act;

  // Lead-off current in nA for a code
  function automatic logic [6:0] na_of(input logic [2:0] code);
    case (code)
      3'h0:    na_of = `LDI_NA_OFF;
      3'h1:    na_of = `LDI_NA_5;
      3'h2:    na_of = `LDI_NA_10;
      3'h3:    na_of = `LDI_NA_20;
      3'h4:    na_of = `LDI_NA_50;
      default: na_of = `LDI_NA_100;
    endcase
  endfunction : na_of

  // Bias resistance in megohm for a code
  function automatic logic [7:0] mohm_of(input logic [1:0] code);
    case (code)
      2'h0:    mohm_of = `LDI_MOHM_50;
      2'h1:    mohm_of = `LDI_MOHM_100;
      default: mohm_of = `LDI_MOHM_200;
    endcase
  endfunction : mohm_of

  // Read data for an address
  function automatic logic [7:0] read_mux(input logic [7:0]  addr,
                                          input ldi_cfg_type c,
                                          input logic [7:0]  e0,
                                          input logic [7:0]  e1,
                                          input logic [7:0]  s0,
                                          input logic [7:0]  s1);
    case (addr)
      `LDI_ADDR_STATUS0: read_mux = s0;
      `LDI_ADDR_STATUS1: read_mux = s1;
      `LDI_ADDR_DCCFG:   read_mux = {c.leadon_detect_enable, c.leadoff_detect_enable,
                                     c.dc_misc, c.leadoff_current_level};
      `LDI_ADDR_THRESH:  read_mux = {4'h0, c.leadoff_window_level};
      `LDI_ADDR_BIAS:    read_mux = {4'h0, c.bias_resistor_select,
                                     c.pos_bias_enable, c.neg_bias_enable};
      `LDI_ADDR_IRQEN0:  read_mux = e0;
      `LDI_ADDR_IRQEN1:  read_mux = e1;
      `LDI_ADDR_CHIPID:  read_mux = CHIP_ID; // Arbitrary identifier value
      default:           read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // Detection gating by channel enables
  assign chan_on   = mode.inphase_channel_enable | mode.quadrature_channel_enable;
  assign loff_live = cfg.leadoff_detect_enable & chan_on;

  // One persistence filter per window comparator output
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_deb
      ldi_debounce #(
        .QUAL_CYCLES (QUAL_CYCLES)
      ) u_deb (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .active  (loff_live),
        .fast    (mode.leadoff_fast_flag),
        .raw     (window_cmp[gi]),
        .flag    (input_off_flags[gi])
      );
    end
  endgenerate

  // Status images seen by software and the interrupt
  assign st0 = status0_in & `LDI_IRQEN0_MASK;
  assign st1 = {status1_hi_in[3] & leadon_detect_active, status1_hi_in[2:0],
                input_off_flags};

  // Register writes
  always_comb begin
    next_cfg = cfg;
    next_en0 = en0;
    next_en1 = en1;
    if (reg_req.wr) begin
      case (reg_req.addr)
        `LDI_ADDR_DCCFG: begin
          {next_cfg.leadon_detect_enable, next_cfg.leadoff_detect_enable,
           next_cfg.dc_misc, next_cfg.leadoff_current_level} = reg_req.wdata;
        end
        `LDI_ADDR_THRESH: begin
          next_cfg.leadoff_window_level = reg_req.wdata[3:0];
        end
        `LDI_ADDR_BIAS: begin
          // Forbidden code keeps the previous selection
          if (reg_req.wdata[`LDI_BIAS_LSB+:2] != `LDI_BIAS_FORBID) begin
            next_cfg.bias_resistor_select = reg_req.wdata[`LDI_BIAS_LSB+:2];
          end
          next_cfg.pos_bias_enable = reg_req.wdata[`LDI_BIAS_POS_BIT];
          next_cfg.neg_bias_enable = reg_req.wdata[`LDI_BIAS_NEG_BIT];
        end
        `LDI_ADDR_IRQEN0: next_en0 = reg_req.wdata & `LDI_IRQEN0_MASK;
        `LDI_ADDR_IRQEN1: next_en1 = reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Read answer one cycle after the request
  always_comb begin
    next_rvalid = reg_req.rd;
    next_rdata  = 8'h00;
    if (reg_req.rd) begin
      next_rdata = read_mux(reg_req.addr, cfg, en0, en1, st0, st1);
    end
  end

  // Decoded analog controls and interrupt
  always_comb begin
    next_cur_en  = (cfg.leadoff_current_level != 3'h0);
    next_na      = na_of(cfg.leadoff_current_level);
    next_win     = `LDI_WIN_BASE_MV
                 + `LDI_WIN_STEP_MV * {6'h00, cfg.leadoff_window_level};
    next_mohm    = mohm_of(cfg.bias_resistor_select);
    next_lon_act = cfg.leadon_detect_enable & ~chan_on;
    next_irq     = (|(st0 & en0)) | (|(st1 & en1));
  end

  // Register state and outputs
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg                   <= '{leadon_detect_enable: 1'b0, leadoff_detect_enable: 1'b0,
                                 dc_misc: 3'h0, leadoff_current_level: 3'h0,
                                 leadoff_window_level: `LDI_RST_THRESH,
                                 bias_resistor_select: `LDI_RST_BIAS,
                                 pos_bias_enable: 1'b0, neg_bias_enable: 1'b0};
      en0                   <= `LDI_RST_IRQEN;
      en1                   <= `LDI_RST_IRQEN;
      reg_rdata             <= 8'h00;
      reg_rvalid            <= 1'b0;
      irq                   <= 1'b0;
      current_source_enable <= 1'b0;
      current_na            <= `LDI_NA_OFF;
      window_mv             <= `LDI_WIN_BASE_MV;
      bias_megohm           <= `LDI_MOHM_50;
      pos_bias_connect      <= 1'b0;
      neg_bias_connect      <= 1'b0;
      leadoff_detect_active <= 1'b0;
      leadon_detect_active  <= 1'b0;
    end else begin
      cfg                   <= next_cfg;
      en0                   <= next_en0;
      en1                   <= next_en1;
      reg_rdata             <= next_rdata;
      reg_rvalid            <= next_rvalid;
      irq                   <= next_irq;
      current_source_enable <= next_cur_en;
      current_na            <= next_na;
      window_mv             <= next_win;
      bias_megohm           <= next_mohm;
      pos_bias_connect      <= cfg.pos_bias_enable;
      neg_bias_connect      <= cfg.neg_bias_enable;
      leadoff_detect_active <= loff_live;
      leadon_detect_active  <= next_lon_act;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_bias_write;
    reg_req.wr && reg_req.addr == `LDI_ADDR_BIAS;
  endsequence
  sequence s_forbid_write;
    s_bias_write ##0 reg_req.wdata[`LDI_BIAS_LSB+:2] == `LDI_BIAS_FORBID;
  endsequence
  sequence s_read_req;
    reg_req.rd;
  endsequence

  // Lead-off current decode
  a_current_zero: assert property (
    cfg.leadoff_current_level == 3'h0 |=> !current_source_enable && current_na == `LDI_NA_OFF)
    else $error("current sources not off at code zero");
  a_current_low: assert property (
    cfg.leadoff_current_level == 3'h1 |=> current_source_enable && current_na == `LDI_NA_5)
    else $error("lowest current code not 5 nA");
  a_current_mid: assert property (
    cfg.leadoff_current_level == 3'h3 |=> current_na == `LDI_NA_20)
    else $error("current code three not 20 nA");
  a_current_top: assert property (
    cfg.leadoff_current_level >= 3'h5 |=> current_na == `LDI_NA_100)
    else $error("top current codes not 100 nA");

  // Window width decode and threshold read-back
  a_window_step: assert property (
    1'b1 |=> (window_mv - `LDI_WIN_BASE_MV)
             == `LDI_WIN_STEP_MV * {6'h00, $past(cfg.leadoff_window_level)})
    else $error("window width wrong for threshold code");
  a_window_top: assert property (
    cfg.leadoff_window_level == 4'hf |=> window_mv == 10'h299)
    else $error("window width not 665 mV at top code");
  a_thresh_read: assert property (
    s_read_req ##0 reg_req.addr == `LDI_ADDR_THRESH |=> reg_rdata[7:4] == 4'h0)
    else $error("threshold upper bits read nonzero");

  // Bias resistor selection and switches
  a_bias_forbid: assert property (
    s_forbid_write |=> $stable(cfg.bias_resistor_select) ##1 $stable(bias_megohm))
    else $error("forbidden bias code was taken");
  a_bias_legal: assert property (
    cfg.bias_resistor_select != `LDI_BIAS_FORBID)
    else $error("bias code holds forbidden value");
  a_bias_low: assert property (
    cfg.bias_resistor_select == 2'h0 |=> bias_megohm == `LDI_MOHM_50)
    else $error("bias code zero not 50 megohm");
  a_bias_mid: assert property (
    cfg.bias_resistor_select == 2'h1 |=> bias_megohm == `LDI_MOHM_100)
    else $error("bias code one not 100 megohm");
  a_bias_high: assert property (
    cfg.bias_resistor_select == 2'h2 |=> bias_megohm == `LDI_MOHM_200)
    else $error("bias code two not 200 megohm");
  a_pos_bias: assert property (
    s_bias_write |-> ##2 pos_bias_connect == $past(reg_req.wdata[`LDI_BIAS_POS_BIT], 2))
    else $error("positive bias connect does not follow write");
  a_neg_bias: assert property (
    s_bias_write |-> ##2 neg_bias_connect == $past(reg_req.wdata[`LDI_BIAS_NEG_BIT], 2))
    else $error("negative bias connect does not follow write");

  // Interrupt gating
  a_irq_status0: assert property (
    (|(st0 & en0)) |=> irq)
    else $error("enabled status-0 bit missed interrupt");
  a_irq_status1: assert property (
    (|(st1 & en1)) |=> irq)
    else $error("enabled status-1 bit missed interrupt");
  a_irq_idle: assert property (
    !(|(st0 & en0)) && !(|(st1 & en1)) |=> !irq)
    else $error("interrupt with no enabled status");
  a_irq_mask: assert property (
    !en0[6] && !en0[0])
    else $error("unused status-0 enable bits set");

  // Detection gating by channel enables
  a_loff_gate: assert property (
    !chan_on |=> input_off_flags == 4'h0)
    else $error("lead-off flags with channels disabled");
  a_loff_active: assert property (
    loff_live |=> leadoff_detect_active)
    else $error("lead-off detection not shown active");
  a_lon_gate: assert property (
    chan_on |=> !leadon_detect_active)
    else $error("lead-on detection with a channel enabled");
  a_lon_status: assert property (
    s_read_req ##0 (reg_req.addr == `LDI_ADDR_STATUS1 && !leadon_detect_active)
    |=> !reg_rdata[7])
    else $error("lead-on status read while detection off");

  // Register read answer
  a_read_answer: assert property (
    s_read_req |=> reg_rvalid)
    else $error("read request without answer");
  a_read_idle: assert property (
    !reg_req.rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read data shown without request");
endmodule : ldi_top

/* File: hdl/ldi_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef LDI_REGS_SVH
`define LDI_REGS_SVH
`define LDI_ADDR_STATUS0  8'h00
`define LDI_ADDR_STATUS1  8'h01
`define LDI_ADDR_DCCFG    8'h50
`define LDI_ADDR_THRESH   8'h51
`define LDI_ADDR_BIAS     8'h58
`define LDI_ADDR_IRQEN0   8'h80
`define LDI_ADDR_IRQEN1   8'h81
`define LDI_ADDR_CHIPID   8'hff
`define LDI_RST_DCCFG     8'h00
`define LDI_RST_THRESH    4'h0
`define LDI_RST_BIAS      2'h0
`define LDI_RST_IRQEN     8'h00
`define LDI_IRQEN0_MASK   8'hbe
`define LDI_CHIPID_VAL    8'h5a
`define LDI_BIAS_FORBID   2'h3
`define LDI_BIAS_LSB      2
`define LDI_BIAS_POS_BIT  1
`define LDI_BIAS_NEG_BIT  0
`define LDI_WIN_BASE_MV   10'h0d7
`define LDI_WIN_STEP_MV   10'h01e
`define LDI_NA_OFF        7'h00
`define LDI_NA_5          7'h05
`define LDI_NA_10         7'h0a
`define LDI_NA_20         7'h14
`define LDI_NA_50         7'h32
`define LDI_NA_100        7'h64
`define LDI_MOHM_50       8'h32
`define LDI_MOHM_100      8'h64
`define LDI_MOHM_200      8'hc8
`define LDI_QUAL_MS       128
`define LDI_CLK_HZ        20000000
`define LDI_QUAL_CYCLES   (`LDI_QUAL_MS * (`LDI_CLK_HZ / 1000))
`define LDI_CNT_W         22
`endif

/* File: hdl/ldi_pkg.sv */
// Types shared by the lead-detect register bank
`include "ldi_regs.svh"
package ldi_pkg;
  // Decoded register access from the serial interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldi_req_type;

  // Channel enables and fast lead-off setting
  typedef struct packed {
    logic inphase_channel_enable;
    logic quadrature_channel_enable;
    logic leadoff_fast_flag;
  } ldi_mode_type;

  // Stored configuration fields
  typedef struct packed {
    logic       leadon_detect_enable;
    logic       leadoff_detect_enable;
    logic [2:0] dc_misc;
    logic [2:0] leadoff_current_level;
    logic [3:0] leadoff_window_level;
    logic [1:0] bias_resistor_select;
    logic       pos_bias_enable;
    logic       neg_bias_enable;
  } ldi_cfg_type;

  typedef enum logic [1:0] {
    DEB_IDLE  = 2'b00,
    DEB_COUNT = 2'b01,
    DEB_OFF   = 2'b10
  } ldi_deb_state_type;
endpackage : ldi_pkg

/* File: hdl/ldi_debounce.sv */
// Persistence filter for one lead-off window comparator output
`timescale 1ns/1ps
`include "ldi_regs.svh"
module ldi_debounce #(
  parameter int unsigned QUAL_CYCLES = `LDI_QUAL_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic active,
  input  wire logic fast,
  input  wire logic raw,
  output logic      flag
);
  import ldi_pkg::*;

  localparam logic [`LDI_CNT_W-1:0] LAST = `LDI_CNT_W'(QUAL_CYCLES - 1);

  ldi_deb_state_type     state;
  ldi_deb_state_type     next_state;
  logic [`LDI_CNT_W-1:0] cnt;
  logic [`LDI_CNT_W-1:0] next_cnt;
  logic                  next_flag;

  // Count consecutive out-of-window samples
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    if (!active) begin
      next_state = DEB_IDLE;
      next_cnt   = '0;
    end else begin
      case (state)
        DEB_IDLE: begin
          if (raw && (fast || LAST == '0)) begin
            next_state = DEB_OFF;
          end else if (raw) begin
            next_state = DEB_COUNT;
            next_cnt   = `LDI_CNT_W'(1);
          end
        end
        DEB_COUNT: begin
          if (!raw) begin
            next_state = DEB_IDLE;
            next_cnt   = '0;
          end else if (fast || cnt == LAST) begin
            next_state = DEB_OFF;
          end else begin
            next_cnt = cnt + `LDI_CNT_W'(1);
          end
        end
        DEB_OFF: begin
          if (!raw) begin
            next_state = DEB_IDLE;
            next_cnt   = '0;
          end
        end
        default: begin
          next_state = DEB_IDLE;
          next_cnt   = '0;
        end
      endcase
    end
    next_flag = (next_state == DEB_OFF);
  end

  // Register filter state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= DEB_IDLE;
      cnt   <= '0;
      flag  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      flag  <= next_flag;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_fast_bypass: assert property (active && fast && raw |=> flag)
    else $error("fast lead-off did not assert at once");
  a_qual_early: assert property (state == DEB_COUNT && cnt != LAST && !fast |=> !flag)
    else $error("lead-off flag set before qualification time");
  a_qual_reach: assert property (
    active && raw && state == DEB_COUNT && cnt == LAST |=> flag)
    else $error("lead-off flag missing after qualification time");
  a_inactive_clear: assert property (!active |=> !flag)
    else $error("lead-off flag set while detection inactive");
endmodule : ldi_debounce

/* File: tb/ldi_host_model.sv */
// Host-side register master issuing single-byte accesses
`timescale 1ns/1ps
module ldi_host_model (
  input  wire logic            sys_clk,
  output ldi_pkg::ldi_req_type reg_req,
  input  wire logic [7:0]      reg_rdata,
  input  wire logic            reg_rvalid
);
  import ldi_pkg::*;
  initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
  // Idle bus shows inverted address and data, never the last value
  task automatic release_bus();
    reg_req.wr    = 1'b0;
    reg_req.rd    = 1'b0;
    reg_req.addr  = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask : release_bus
  // One write, returns once decoded outputs have settled
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge sys_clk);
    #5;
    release_bus();
    @(posedge sys_clk);
    #5;
  endtask : write_reg
  // One read, answer taken in the cycle after the taking edge
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: reg_req.wdata};
    @(posedge sys_clk);
    #5;
    release_bus();
    data  = reg_rdata;
    valid = reg_rvalid;
    @(posedge sys_clk);
    #5;
  endtask : read_reg
endmodule : ldi_host_model

/* File: tb/tb_ldi_top.sv */
// Self-checking bench for the lead-detect register bank
`timescale 1ns/1ps
`include "ldi_regs.svh"
module tb_ldi_top;
  import ldi_pkg::*;
  localparam int unsigned QUAL = 4;
  localparam logic [7:0]  CHIP = 8'h3c; // Arbitrary identifier value
  logic         sys_clk = 1'b0;
  logic         reset_n = 1'b0;
  ldi_req_type  reg_req;
  ldi_mode_type mode = '0;
  logic [7:0]   reg_rdata, status0_in = 8'h00, rd_data;
  logic [3:0]   window_cmp = 4'h0, status1_hi_in = 4'h0, input_off_flags;
  logic         reg_rvalid, irq, current_source_enable, rd_valid;
  logic         pos_bias_connect, neg_bias_connect, leadoff_detect_active, leadon_detect_active;
  logic [6:0]   current_na;
  logic [9:0]   window_mv;
  logic [7:0]   bias_megohm;
  int           failures = 0, n_compared = 0, cycles = 0;
  int           na_tab[8] = '{0, 5, 10, 20, 50, 100, 100, 100};
  int           mo_tab[3] = '{50, 100, 200};
  always #25 sys_clk = ~sys_clk;
  ldi_host_model host_u (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
                         .reg_rvalid(reg_rvalid));
  ldi_top #(.QUAL_CYCLES(QUAL), .CHIP_ID(CHIP)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .mode(mode), .window_cmp(window_cmp), .status0_in(status0_in),
    .status1_hi_in(status1_hi_in), .irq(irq), .current_source_enable(current_source_enable),
    .current_na(current_na), .window_mv(window_mv), .bias_megohm(bias_megohm),
    .pos_bias_connect(pos_bias_connect), .neg_bias_connect(neg_bias_connect),
    .leadoff_detect_active(leadoff_detect_active), .leadon_detect_active(leadon_detect_active),
    .input_off_flags(input_off_flags));
  // Verdict and end of run
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // Compare and count
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.write_reg(a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_u.read_reg(a, rd_data, rd_valid);
    chk("reg_rvalid", 10'h001, {9'h000, rd_valid});
    chk("reg_rdata", {2'b00, exp}, {2'b00, rd_data});
  endtask : rd_chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : tick
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    tick(12);
    reset_n = 1'b1;
    chk("window_mv", 10'd215, window_mv);
    chk("bias_megohm", 10'd50, {2'b00, bias_megohm});
    rd_chk(`LDI_ADDR_THRESH, 8'h00);
    rd_chk(`LDI_ADDR_BIAS, 8'h00);
    rd_chk(`LDI_ADDR_IRQEN0, 8'h00);
    rd_chk(`LDI_ADDR_IRQEN1, 8'h00);
    wr(`LDI_ADDR_CHIPID, 8'h00);
    rd_chk(`LDI_ADDR_CHIPID, CHIP);
    wr(8'h33, 8'hff);
    rd_chk(8'h33, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(`LDI_ADDR_DCCFG, 8'(k));
      chk("current_na", 10'(na_tab[k]), {3'b000, current_na});
      chk("current_source_enable", {9'h000, k != 0}, {9'h000, current_source_enable});
    end
    rd_chk(`LDI_ADDR_DCCFG, 8'h07);
    for (int k = 0; k < 16; k++) begin
      wr(`LDI_ADDR_THRESH, {4'hf, 4'(k)});
      chk("window_mv", 10'(215 + 30 * k), window_mv);
      rd_chk(`LDI_ADDR_THRESH, 8'(k));
    end
    for (int k = 0; k < 3; k++) begin
      wr(`LDI_ADDR_BIAS, 8'(k * 4 + 2));
      chk("bias_megohm", 10'(mo_tab[k]), {2'b00, bias_megohm});
      chk("pos_neg", 10'h002, {8'h00, pos_bias_connect, neg_bias_connect});
    end
    wr(`LDI_ADDR_BIAS, 8'h0d);
    chk("bias_megohm", 10'd200, {2'b00, bias_megohm});
    chk("pos_neg", 10'h001, {8'h00, pos_bias_connect, neg_bias_connect});
    rd_chk(`LDI_ADDR_BIAS, 8'h09);
    status0_in = 8'hff;
    tick(2);
    chk("irq", 10'h000, {9'h000, irq});
    for (int b = 0; b < 8; b++) begin
      wr(`LDI_ADDR_IRQEN0, 8'(1 << b));
      chk("irq", {9'h000, b != 0 && b != 6}, {9'h000, irq});
    end
    wr(`LDI_ADDR_IRQEN0, 8'hff);
    rd_chk(`LDI_ADDR_IRQEN0, 8'hbe);
    rd_chk(`LDI_ADDR_STATUS0, 8'hbe);
    status0_in = 8'h41;
    tick(1);
    chk("irq", 10'h000, {9'h000, irq});
    status0_in = 8'h00;
    status1_hi_in = 4'hf;
    wr(`LDI_ADDR_DCCFG, 8'h80);
    chk("leadon_detect_active", 10'h001, {9'h000, leadon_detect_active});
    for (int b = 4; b < 8; b++) begin
      wr(`LDI_ADDR_IRQEN1, 8'(1 << b));
      chk("irq", 10'h001, {9'h000, irq});
    end
    rd_chk(`LDI_ADDR_STATUS1, 8'hf0);
    mode.inphase_channel_enable = 1'b1;
    tick(2);
    chk("leadon_detect_active", 10'h000, {9'h000, leadon_detect_active});
    chk("irq", 10'h000, {9'h000, irq});
    status1_hi_in = 4'h0;
    wr(`LDI_ADDR_DCCFG, 8'h40);
    wr(`LDI_ADDR_IRQEN1, 8'h0f);
    chk("leadoff_detect_active", 10'h001, {9'h000, leadoff_detect_active});
    for (int b = 0; b < 4; b++) begin
      window_cmp = 4'(1 << b);
      tick(QUAL - 1);
      window_cmp = 4'h0;
      tick(1);
      window_cmp = 4'(1 << b);
      tick(QUAL - 1);
      chk("input_off_flags", 10'h000, {6'h00, input_off_flags});
      tick(1);
      chk("input_off_flags", 10'(1 << b), {6'h00, input_off_flags});
      tick(1);
      chk("irq", 10'h001, {9'h000, irq});
      window_cmp = 4'h0;
      tick(2);
      chk("irq", 10'h000, {9'h000, irq});
    end
    mode.leadoff_fast_flag = 1'b1;
    window_cmp = 4'h8;
    tick(1);
    chk("input_off_flags", 10'h008, {6'h00, input_off_flags});
    mode.inphase_channel_enable = 1'b0;
    tick(2);
    chk("input_off_flags", 10'h000, {6'h00, input_off_flags});
    chk("leadoff_detect_active", 10'h000, {9'h000, leadoff_detect_active});
    mode.quadrature_channel_enable = 1'b1;
    tick(2);
    rd_chk(`LDI_ADDR_STATUS1, 8'h08);
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    chk("window_mv", 10'd215, window_mv);
    chk("bias_megohm", 10'd50, {2'b00, bias_megohm});
    chk("irq", 10'h000, {9'h000, irq});
    rd_chk(`LDI_ADDR_IRQEN1, 8'h00);
    final_report();
  end
endmodule : tb_ldi_top
